// file: vpr_pkg.sv
// package: vector numbers, offsets, levels and carrier types for the priority resolver
package vpr_pkg;
  localparam int unsigned VEC_W        = 5;
  localparam int unsigned ADDR_W       = 21;
  localparam int unsigned NUM_VEC      = 14;
  localparam int unsigned LVL_W        = 2;
  localparam int unsigned FIELD_W      = 2;
  localparam int unsigned NUM_PROG     = 5;
  localparam int unsigned ENTRY_STRIDE = 2;
  localparam logic [4:0] VEC_CHIP_RESET  = 5'h00;
  localparam logic [4:0] VEC_WDOG_RESET  = 5'h01;
  localparam logic [4:0] VEC_FIXED3_LO   = 5'h02;
  localparam logic [4:0] VEC_FIXED3_HI   = 5'h05;
  localparam logic [4:0] VEC_PROG_LO     = 5'h06;
  localparam logic [4:0] VEC_PROG_HI     = 5'h0a;
  localparam logic [4:0] VEC_SWI2        = 5'h0b;
  localparam logic [4:0] VEC_SWI1        = 5'h0c;
  localparam logic [4:0] VEC_SWI0        = 5'h0d;
  localparam logic [1:0] LVL_SWI2        = 2'h2;
  localparam logic [1:0] LVL_SWI1        = 2'h1;
  localparam logic [1:0] LVL_SWI0        = 2'h0;
  localparam logic [1:0] LVL_FIXED       = 2'h3;
  localparam logic [1:0] FIELD_DISABLED  = 2'h0;
  localparam logic [9:0] PROG_LVL_RESET  = 10'h000;
  localparam logic [20:0] BASE_RESET     = 21'h000000;
  localparam logic [1:0] CUR_NONE        = 2'h0;
  localparam logic [1:0] CUR_P0          = 2'h1;
  localparam logic [1:0] CUR_P1          = 2'h2;
  localparam logic [1:0] CUR_P23         = 2'h3;

  typedef struct packed {
    logic        valid;
    logic [4:0]  vec;
    logic [1:0]  lvl;
    logic [20:0] addr;
  } vec_req_t;
endpackage

// file: vpr_rank.sv
// leaf: per-vector pending, level and acceptance decode
`timescale 1ns/1ps
module vpr_rank #(
  parameter int unsigned NUM_VEC = vpr_pkg::NUM_VEC
) (
  // requests and levels
  input  wire logic [NUM_VEC-1:0]  pend_i,
  input  wire logic [9:0]          prog_lvl_i,
  input  wire logic [1:0]          cur_field_i,
  input  wire logic                dis_i,
  // candidates per level
  output logic [3:0][NUM_VEC-1:0]  cand_o
);
  function automatic logic [1:0] vec_level(input int unsigned v, input logic [9:0] pl);
    logic [1:0] f;
    f = 2'h0;
    if (v >= 2 && v <= 5) begin
      f = vpr_pkg::LVL_FIXED;
    end else if (v >= 6 && v <= 10) begin
      f = pl[(v-6)*2 +: 2];
    end else if (v == 11) begin
      f = vpr_pkg::LVL_SWI2;
    end else if (v == 12) begin
      f = vpr_pkg::LVL_SWI1;
    end else begin
      f = vpr_pkg::LVL_SWI0;
    end
    return f;
  endfunction

  function automatic logic accepted(input logic [1:0] lvl, input logic [1:0] cur);
    logic ok;
    ok = 1'b0;
    case (cur)
      vpr_pkg::CUR_NONE: ok = 1'b1;
      vpr_pkg::CUR_P0:   ok = (lvl >= 2'h1);
      vpr_pkg::CUR_P1:   ok = (lvl >= 2'h2);
      vpr_pkg::CUR_P23:  ok = (lvl == 2'h3);
      default:           ok = 1'b0;
    endcase
    return ok;
  endfunction

  for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
    for (genvar l = 0; l < 4; l++) begin : g_lvl
      wire logic prog_off;
      assign prog_off = (v >= 6 && v <= 10) &&
                        (prog_lvl_i[((v >= 6 && v <= 10) ? v - 6 : 0)*2 +: 2] ==
                         vpr_pkg::FIELD_DISABLED);
      assign cand_o[l][v] = (v >= 2) && pend_i[v] && !dis_i && !prog_off &&
                            (vec_level(v, prog_lvl_i) == 2'(l)) &&
                            accepted(2'(l), cur_field_i);
    end
  end
endmodule // vpr_rank

// file: vectored_priority_resolver.sv
// top: vectored priority resolver presenting winning vector address to the core
// Summary of operation
// - all pending level 3 requests win over level 2, then 1, then 0.
// - within one level the lowest vector number wins.
// - a vector address is the table base plus a fixed per-vector offset.
// - chip reset uses entry 0 and watchdog reset entry 1 at base plus offset.
// - entries are two words apart so vector n sits at offset 2n.
// - vectors 2 to 5 are always level 3.
// - vectors 6 to 10 take a software-chosen level 1 to 3.
// - software interrupts 2, 1, 0 are vectors 11, 12, 13 at levels 2, 1, 0.
// - each programmable level field is 2 bits, 00 disabled at reset, else levels 1 to 3.
// - a nested request is accepted only at or above the current priority field.
// - the global disable blocks requests of vectors 2 to 13 while set; chip and watchdog resets still pass.
`timescale 1ns/1ps
module vectored_priority_resolver #(
  parameter int unsigned NUM_VEC = vpr_pkg::NUM_VEC
) (
  // clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_b_i,
  // sources, same clock domain
  input  wire logic [NUM_VEC-1:0]         req_i,
  input  wire logic                       chip_reset_req_i,
  input  wire logic                       watchdog_reset_source_i,
  // configuration
  input  wire logic [vpr_pkg::ADDR_W-1:0] vector_table_base_i,
  input  wire logic [9:0]                 prog_lvl_i,
  input  wire logic [1:0]                 current_priority_field_i,
  input  wire logic                       global_interrupt_disable_i,
  // core handshake
  input  wire logic                       ack_i,
  // outputs to core
  output logic                            vec_valid_o,
  output logic [vpr_pkg::VEC_W-1:0]       vec_num_o,
  output logic [vpr_pkg::LVL_W-1:0]       vec_lvl_o,
  output logic [vpr_pkg::ADDR_W-1:0]      vec_addr_o,
  output logic [NUM_VEC-1:0]              pend_o
);
  // reset synchroniser
  logic                       rst_s1_r;
  logic                       rst_s2_r;

  // pending set and output register
  logic [NUM_VEC-1:0]         req_used;
  logic [NUM_VEC-1:0]         pend_r;
  logic [NUM_VEC-1:0]         pend_nxt;
  logic [NUM_VEC-1:0]         clr;
  vpr_pkg::vec_req_t          out_r;
  vpr_pkg::vec_req_t          out_nxt;

  // candidates of each level from the rank stage
  logic [3:0][NUM_VEC-1:0]    cand;

  function automatic logic [20:0] entry_addr(input logic [20:0] base, input logic [4:0] v);
    return base + 21'(v) * 21'(vpr_pkg::ENTRY_STRIDE);
  endfunction

  function automatic logic [4:0] lowest(input logic [NUM_VEC-1:0] m);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // carrier for one source, already holding its table address
  function automatic vpr_pkg::vec_req_t make_req(
    input logic                       valid,
    input logic [vpr_pkg::VEC_W-1:0]  vec,
    input logic [vpr_pkg::LVL_W-1:0]  lvl,
    input logic [vpr_pkg::ADDR_W-1:0] base
  );
    vpr_pkg::vec_req_t q;
    q       = '0;
    q.valid = valid;
    q.vec   = valid ? vec : '0;
    q.lvl   = valid ? lvl : '0;
    q.addr  = entry_addr(base, q.vec);
    return q;
  endfunction

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // level decode and acceptance per vector
  vpr_rank #(
    .NUM_VEC(NUM_VEC)
  ) u_rank (
    .pend_i      (pend_r),
    .prog_lvl_i  (prog_lvl_i),
    .cur_field_i (current_priority_field_i),
    .dis_i       (global_interrupt_disable_i),
    .cand_o      (cand)
  );

  // candidate mask of each level
  wire logic [NUM_VEC-1:0]         cand3;
  wire logic [NUM_VEC-1:0]         cand2;
  wire logic [NUM_VEC-1:0]         cand1;
  wire logic [NUM_VEC-1:0]         cand0;
  assign cand3 = cand[3];
  assign cand2 = cand[2];
  assign cand1 = cand[1];
  assign cand0 = cand[0];

  // any candidate and lowest candidate of each level
  wire logic                       any3;
  wire logic                       any2;
  wire logic                       any1;
  wire logic                       any0;
  wire logic [vpr_pkg::VEC_W-1:0]  win3;
  wire logic [vpr_pkg::VEC_W-1:0]  win2;
  wire logic [vpr_pkg::VEC_W-1:0]  win1;
  wire logic [vpr_pkg::VEC_W-1:0]  win0;
  assign any3 = |cand3;
  assign any2 = |cand2;
  assign any1 = |cand1;
  assign any0 = |cand0;
  assign win3 = lowest(cand3);
  assign win2 = lowest(cand2);
  assign win1 = lowest(cand1);
  assign win0 = lowest(cand0);

  // one carrier per source
  vpr_pkg::vec_req_t               pick_chip;
  vpr_pkg::vec_req_t               pick_wdog;
  vpr_pkg::vec_req_t               pick3;
  vpr_pkg::vec_req_t               pick2;
  vpr_pkg::vec_req_t               pick1;
  vpr_pkg::vec_req_t               pick0;
  vpr_pkg::vec_req_t               pick_idle;
  assign pick_chip = make_req(1'b1, vpr_pkg::VEC_CHIP_RESET, vpr_pkg::LVL_FIXED,
                              vector_table_base_i);
  assign pick_wdog = make_req(1'b1, vpr_pkg::VEC_WDOG_RESET, vpr_pkg::LVL_FIXED,
                              vector_table_base_i);
  assign pick3     = make_req(1'b1, win3, 2'h3, vector_table_base_i);
  assign pick2     = make_req(1'b1, win2, 2'h2, vector_table_base_i);
  assign pick1     = make_req(1'b1, win1, 2'h1, vector_table_base_i);
  assign pick0     = make_req(1'b1, win0, 2'h0, vector_table_base_i);
  assign pick_idle = make_req(1'b0, 5'h00, 2'h0, vector_table_base_i);

  // a source is chosen only when nothing above it wants the core
  wire logic                       above_wdog;
  wire logic                       above3;
  wire logic                       above2;
  wire logic                       above1;
  wire logic                       above0;
  assign above_wdog = chip_reset_req_i;
  assign above3     = above_wdog || watchdog_reset_source_i;
  assign above2     = above3 || any3;
  assign above1     = above2 || any2;
  assign above0     = above1 || any1;

  // resets first, then level 3 down to level 0
  wire logic                       sel_chip;
  wire logic                       sel_wdog;
  wire logic                       sel3;
  wire logic                       sel2;
  wire logic                       sel1;
  wire logic                       sel0;
  assign sel_chip = chip_reset_req_i;
  assign sel_wdog = !above_wdog && watchdog_reset_source_i;
  assign sel3     = !above3 && any3;
  assign sel2     = !above2 && any2;
  assign sel1     = !above1 && any1;
  assign sel0     = !above0 && any0;

  // exactly one carrier reaches the output register
  assign out_nxt = sel_chip ? pick_chip :
                   sel_wdog ? pick_wdog :
                   sel3     ? pick3     :
                   sel2     ? pick2     :
                   sel1     ? pick1     :
                   sel0     ? pick0     :
                              pick_idle;

  // acceptance clears only the presented vector
  wire logic                       take;
  wire logic [NUM_VEC-1:0]         take_bit;
  assign take     = ack_i && out_r.valid;
  assign take_bit = NUM_VEC'(1) << out_r.vec;
  assign clr      = take ? take_bit : '0;

  // bits 0 and 1 name the reset entries, which never wait as pending
  assign req_used = req_i & ~NUM_VEC'(2'h3);
  // new request wins over a clear in the same cycle
  assign pend_nxt = (pend_r & ~clr) | req_used;

  // pending flags
  always_ff @(posedge core_clk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // presented vector, re-ranked every cycle
  always_ff @(posedge core_clk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  // outputs straight from the registers
  assign vec_valid_o = out_r.valid;
  assign vec_num_o   = out_r.vec;
  assign vec_lvl_o   = out_r.lvl;
  assign vec_addr_o  = out_r.addr;
  assign pend_o      = pend_r;
endmodule // vectored_priority_resolver

// file: vpr_checker.sv
// checker: port-level rules of the priority resolver
`timescale 1ns/1ps
module vpr_checker (
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  // sources and configuration
  input wire logic [13:0] req_i,
  input wire logic        chip_reset_req_i,
  input wire logic        watchdog_reset_source_i,
  input wire logic [20:0] vector_table_base_i,
  input wire logic [9:0]  prog_lvl_i,
  input wire logic [1:0]  current_priority_field_i,
  input wire logic        global_interrupt_disable_i,
  // outputs to core
  input wire logic        vec_valid_o,
  input wire logic [4:0]  vec_num_o,
  input wire logic [1:0]  vec_lvl_o,
  input wire logic [20:0] vec_addr_o,
  // core handshake and pending set
  input wire logic        ack_i,
  input wire logic [13:0] pend_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_irq;
    vec_valid_o && vec_num_o > 5'h01;
  endsequence
  sequence s_take;
    ack_i && vec_valid_o && vec_num_o > 5'h01;
  endsequence
  a_addr_base_plus: assert property (vec_valid_o |->
    vec_addr_o == $past(vector_table_base_i) + {vec_num_o, 1'b0}) else $error("bad address");
  a_chip_first: assert property (chip_reset_req_i |=>
    vec_valid_o && vec_num_o == 5'h00) else $error("bad chip reset vector");
  a_wdog_second: assert property (watchdog_reset_source_i && !chip_reset_req_i |=>
    vec_valid_o && vec_num_o == 5'h01) else $error("bad watchdog vector");
  a_fixed_top: assert property (s_irq ##0 vec_num_o < 5'h06 |->
    vec_lvl_o == 2'h3) else $error("fixed vector level");
  a_soft_levels: assert property (s_irq ##0 vec_num_o > 5'h0a |->
    vec_lvl_o == 2'(5'h0d - vec_num_o)) else $error("software vector level");
  a_prog_field: assert property (s_irq ##0 vec_num_o inside {[5'h06:5'h0a]} |->
    vec_lvl_o != 2'h0 && vec_lvl_o == 2'($past(prog_lvl_i) >> {vec_num_o - 5'h06, 1'b0}))
    else $error("programmable level");
  a_above_current: assert property (s_irq |->
    vec_lvl_o >= $past(current_priority_field_i)) else $error("level not above current");
  a_disable_blocks: assert property (global_interrupt_disable_i && !chip_reset_req_i &&
    !watchdog_reset_source_i |=> !vec_valid_o) else $error("presented while disabled");
  a_take_clears: assert property (s_take ##0 !req_i[vec_num_o] |=>
    !pend_o[$past(vec_num_o)]) else $error("taken vector still pending");
endmodule // vpr_checker
bind vectored_priority_resolver vpr_checker u_chk (.*);

// file: vpr_core_model.sv
// partner: core that takes a presented vector when allowed
`timescale 1ns/1ps
module vpr_core_model (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic en_i,
  input  wire logic vec_valid_i,
  output logic      ack_o
);
  logic ack_d_r;
  // one-cycle take, then skip the stale cycle after it
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i) {ack_o, ack_d_r} <= 2'h0;
    else {ack_o, ack_d_r} <= {en_i & vec_valid_i & ~ack_o & ~ack_d_r, ack_o};
endmodule // vpr_core_model

// file: testbench.sv
// testbench: directed scenarios for the priority resolver
`timescale 1ns/1ps
module testbench;
  logic        core_clk_i = 1'b0, rst_b_i = 1'b0, en = 1'b0, ack_i, vec_valid_o;
  logic        chip_reset_req_i = 1'b0, watchdog_reset_source_i = 1'b0;
  logic        global_interrupt_disable_i = 1'b0;
  logic [13:0] req_i = 14'h0000, pend_o;
  logic [20:0] vector_table_base_i = 21'h001000, vec_addr_o;
  logic [9:0]  prog_lvl_i = 10'h000;
  logic [1:0]  current_priority_field_i = 2'h0, vec_lvl_o;
  logic [4:0]  vec_num_o;
  logic [22:0] took[$];
  int          fails = 0, checked = 0, cyc = 0;
  always #25 core_clk_i = ~core_clk_i;
  vectored_priority_resolver u_dut (.core_clk_i, .rst_b_i, .req_i, .chip_reset_req_i,
    .watchdog_reset_source_i, .vector_table_base_i, .prog_lvl_i, .current_priority_field_i,
    .global_interrupt_disable_i, .ack_i, .vec_valid_o, .vec_num_o, .vec_lvl_o, .vec_addr_o,
    .pend_o);
  vpr_core_model u_core (.clk_i(core_clk_i), .rst_b_i, .en_i(en), .vec_valid_i(vec_valid_o),
    .ack_o(ack_i));
  always @(posedge core_clk_i) if (ack_i && vec_valid_o) took.push_back({vec_lvl_o, vec_addr_o});
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic pulse(input logic [13:0] bits);
    @(posedge core_clk_i) req_i <= bits;
    @(posedge core_clk_i) req_i <= 14'h0000;
  endtask
  task automatic t_rank;
    int         n[6] = '{2, 3, 11, 6, 12, 13};
    logic [1:0] l[6] = '{3, 3, 2, 1, 1, 0};
    @(posedge core_clk_i) prog_lvl_i <= 10'h001;
    pulse(14'h38cc);
    step(2);
    check(vec_num_o, 5'h02);
    @(posedge core_clk_i) en <= 1'b1;
    step(30);
    check(took.size(), 6);
    foreach (n[i]) check(took[i], {l[i], 21'h001000 + 21'(2 * n[i])});
    check({vec_valid_o, pend_o}, 15'h0080);
    @(posedge core_clk_i) prog_lvl_i <= 10'h00c;
    step(4);
    check(took.size(), 7);
    check(took[6], {2'h3, 21'h00100e});
    check({vec_valid_o, pend_o}, 15'h0000);
  endtask
  task automatic t_mask;
    @(posedge core_clk_i) en <= 1'b0;
    current_priority_field_i <= 2'h3;
    pulse(14'h0800);
    step(3);
    check({vec_valid_o, pend_o}, 15'h0800);
    @(posedge core_clk_i) current_priority_field_i <= 2'h2;
    step(2);
    check({vec_valid_o, vec_num_o}, 6'h2b);
    @(posedge core_clk_i) global_interrupt_disable_i <= 1'b1;
    step(2);
    check(vec_valid_o, 1'b0);
    @(posedge core_clk_i) global_interrupt_disable_i <= 1'b0;
    en <= 1'b1;
    step(6);
    check(pend_o, 14'h0000);
  endtask
  task automatic t_resets;
    @(posedge core_clk_i) {chip_reset_req_i, watchdog_reset_source_i} <= 2'h3;
    {en, global_interrupt_disable_i} <= 2'h1;
    step(2);
    check({vec_valid_o, vec_num_o, vec_addr_o}, {6'h20, 21'h001000});
    @(posedge core_clk_i) chip_reset_req_i <= 1'b0;
    vector_table_base_i <= 21'h0abc00;
    step(2);
    check({vec_valid_o, vec_num_o, vec_addr_o}, {6'h21, 21'h0abc02});
    @(posedge core_clk_i) watchdog_reset_source_i <= 1'b0;
    step(2);
    check(vec_valid_o, 1'b0);
  endtask
  task automatic wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      wrap_up;
    end
  end
  initial begin
    step(10);
    @(posedge core_clk_i) rst_b_i <= 1'b1;
    step(4);
    t_rank;
    t_mask;
    t_resets;
    wrap_up;
  end
endmodule // testbench
